// ### rtl/gpr_and_exception_state_regs_pkg.sv
// Shared constants and state layout for the register file and exception state
package gpr_and_exception_state_regs_pkg;
	localparam int XLEN = 64;
	localparam int WLEN = 32;
	localparam int NUM_GPR = 31;
	localparam int NUM_EL = 4;
	localparam int NUM_BANKED = 3;
	localparam logic [4:0] ZERO_IDX = 5'h1F;
	localparam logic [1:0] BASE_EL = 2'h0;
	localparam logic [1:0] EL1 = 2'h1;
	localparam logic [1:0] EL3 = 2'h3;
	localparam logic [WLEN-1:0] UPPER_ZERO = 32'h0000_0000;
	// Saved-state field positions
	localparam int N_BIT = 31;
	localparam int Z_BIT = 30;
	localparam int C_BIT = 29;
	localparam int V_BIT = 28;
	localparam int SS_BIT = 21;
	localparam int BAD_STATE_BIT = 20;
	localparam int D_BIT = 9;
	localparam int A_BIT = 8;
	localparam int I_BIT = 7;
	localparam int F_BIT = 6;
	localparam int M_STATE_BIT = 4;
	localparam int M_EL_LO = 2;
	localparam int M_SPSEL_BIT = 0;
	// Reset state: highest level, own stack pointer, all masks set
	localparam logic [1:0] RESET_EL = 2'h3;
	localparam logic RESET_SPSEL = 1'b1;
	localparam logic [3:0] RESET_MASKS = 4'hF;
	// Saved-state / return-address access select
	localparam logic SR_SEL_STATE = 1'b0;
	localparam logic SR_SEL_RETADDR = 1'b1;

	typedef struct packed {
		logic [NUM_GPR-1:0][XLEN-1:0] wide_gprs;
		logic [NUM_EL-1:0][XLEN-1:0] stack_ptr;
		logic [NUM_BANKED-1:0][XLEN-1:0] return_address_reg;
		logic [NUM_BANKED-1:0][WLEN-1:0] saved_state_reg;
		logic [1:0] cur_el;
		logic sp_sel;
		logic [3:0] nzcv;
		logic soft_step;
		logic bad_state_flag;
		logic [3:0] masks;
		logic exec_state;
		logic [XLEN-1:0] rd_a_data;
		logic [XLEN-1:0] rd_b_data;
		logic [XLEN-1:0] sr_rd_data;
		logic [XLEN-1:0] resume_pc;
		logic resume_valid;
	} regs_state_t;
endpackage

// ### rtl/gpr_and_exception_state_regs.sv
// Register file, banked stack pointers and exception return state
//
// Functional notes
// RL1: Thirty-one 64-bit general registers, readable and writable at every level.
// RL2: Narrow read returns low 32 bits; upper 32 bits read as zero.
// RL3: Narrow write stores low half and zeroes the upper 32 bits.
// RL4: Index 31 normally selects the zero register; no storage exists there.
// RL5: Index 31 in stack-pointer operand positions selects the active stack pointer.
// RL6: Zero register reads 0 in both widths; writes are discarded.
// RL7: Four stack pointers, one per level 0 to 3, no return state.
// RL8: Return address and saved state banked for levels 1, 2, 3 only.
// RL9: Taking an exception selects the target level's own stack pointer.
// RL10: Above level 0 the active pointer is own or base pointer.
// RL11: At level 0 only the base stack pointer is active.
// RL12: Only stack-pointer operand forms such as add reach the stack pointer.
// RL13: Program counter is not a named register nor a write destination.
// RL14: Target level return-address register captures the resume address.
// RL15: Entry copies processor state into saved state; return restores from it.
// RL16: Saved state flags N, Z, C, V in bits 31 to 28.
// RL17: Saved state bit 21 software step, bit 20 bad state flag.
// RL18: Saved state masks D, A, I, F in bits 9 to 6.
// RL19: Bit 4 source execution state, zero is 64-bit; bits 3:0 source mode.
// RL20: Saved state written is the one of the target level 1 to 3.
// RL21: Banked pair of a level holds while running at lower levels.
// RL22: Exception return restores saved state and resumes at return address.
// RL23: Entry updates saved state, return address and stack pointer together.
`timescale 1ns/1ps
module gpr_and_exception_state_regs (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// Read port A
	input wire logic [4:0] rd_a_idx,
	input wire logic rd_a_narrow,
	input wire logic rd_a_sp_form,
	output logic [63:0] rd_a_data,
	// Read port B
	input wire logic [4:0] rd_b_idx,
	input wire logic rd_b_narrow,
	input wire logic rd_b_sp_form,
	output logic [63:0] rd_b_data,
	// Write port
	input wire logic wr_en,
	input wire logic [4:0] wr_idx,
	input wire logic wr_narrow,
	input wire logic wr_sp_form,
	input wire logic [63:0] wr_data,
	// Processor state updates
	input wire logic flags_we,
	input wire logic [3:0] flags_in,
	input wire logic ctrl_we,
	input wire logic [3:0] masks_in,
	input wire logic sp_sel_in,
	input wire logic soft_step_in,
	input wire logic bad_state_in,
	// Exception entry and return
	input wire logic exc_take,
	input wire logic [1:0] exc_target_el,
	input wire logic [63:0] exc_return_addr,
	input wire logic exception_return_op,
	output logic [63:0] resume_pc,
	output logic resume_valid,
	// Saved-state and return-address access
	input wire logic sr_rd_en,
	input wire logic sr_wr_en,
	input wire logic sr_sel,
	input wire logic [1:0] sr_el,
	input wire logic [63:0] sr_wr_data,
	output logic [63:0] sr_rd_data,
	// Current processor state
	output logic [1:0] cur_el,
	output logic sp_sel,
	output logic [3:0] nzcv,
	output logic [3:0] masks,
	output logic soft_step,
	output logic bad_state_flag,
	output logic exec_state
);
	gpr_and_exception_state_regs_pkg::regs_state_t st_reg;
	gpr_and_exception_state_regs_pkg::regs_state_t st_next;

	function automatic logic [1:0] active_sp_idx(input logic [1:0] el, input logic sel);
		active_sp_idx = (el == gpr_and_exception_state_regs_pkg::BASE_EL || !sel) ?
			gpr_and_exception_state_regs_pkg::BASE_EL : el; // [RL10] [RL11]
	endfunction

	function automatic logic [63:0] read_reg(
		input gpr_and_exception_state_regs_pkg::regs_state_t s,
		input logic [4:0] idx, input logic narrow, input logic sp_form);
		logic [63:0] v;
		v = '0;
		if (idx != gpr_and_exception_state_regs_pkg::ZERO_IDX) begin
			v = s.wide_gprs[idx]; // [RL1]
		end else if (sp_form) begin
			v = s.stack_ptr[active_sp_idx(s.cur_el, s.sp_sel)]; // [RL5] [RL12]
		end else begin
			v = '0; // [RL4] [RL6]
		end
		if (narrow) begin
			v = {gpr_and_exception_state_regs_pkg::UPPER_ZERO, v[31:0]}; // [RL2]
		end
		read_reg = v;
	endfunction

	function automatic logic [31:0] pack_state(
		input gpr_and_exception_state_regs_pkg::regs_state_t s);
		logic [31:0] p;
		p = '0;
		p[gpr_and_exception_state_regs_pkg::N_BIT] = s.nzcv[3]; // [RL16]
		p[gpr_and_exception_state_regs_pkg::Z_BIT] = s.nzcv[2];
		p[gpr_and_exception_state_regs_pkg::C_BIT] = s.nzcv[1];
		p[gpr_and_exception_state_regs_pkg::V_BIT] = s.nzcv[0];
		p[gpr_and_exception_state_regs_pkg::SS_BIT] = s.soft_step; // [RL17]
		p[gpr_and_exception_state_regs_pkg::BAD_STATE_BIT] = s.bad_state_flag;
		p[gpr_and_exception_state_regs_pkg::D_BIT] = s.masks[3]; // [RL18]
		p[gpr_and_exception_state_regs_pkg::A_BIT] = s.masks[2];
		p[gpr_and_exception_state_regs_pkg::I_BIT] = s.masks[1];
		p[gpr_and_exception_state_regs_pkg::F_BIT] = s.masks[0];
		p[gpr_and_exception_state_regs_pkg::M_STATE_BIT] = s.exec_state; // [RL19]
		p[gpr_and_exception_state_regs_pkg::M_EL_LO +: 2] = s.cur_el;
		p[gpr_and_exception_state_regs_pkg::M_SPSEL_BIT] = s.sp_sel;
		pack_state = p;
	endfunction

	logic [1:0] act_sp;
	logic [1:0] exc_bank;
	logic [1:0] cur_bank;
	logic [1:0] sr_bank;
	logic [31:0] restore;
	logic return_ok;
	logic [63:0] wval;

	always_comb begin
		st_next = st_reg;
		act_sp = active_sp_idx(st_reg.cur_el, st_reg.sp_sel);
		exc_bank = exc_target_el - gpr_and_exception_state_regs_pkg::EL1;
		cur_bank = st_reg.cur_el - gpr_and_exception_state_regs_pkg::EL1;
		sr_bank = sr_el - gpr_and_exception_state_regs_pkg::EL1;
		// Bank index wraps at level 0; unused there since return is refused
		restore = st_reg.saved_state_reg[cur_bank];
		return_ok = exception_return_op &&
			st_reg.cur_el != gpr_and_exception_state_regs_pkg::BASE_EL;
		wval = wr_narrow ? {gpr_and_exception_state_regs_pkg::UPPER_ZERO, wr_data[31:0]} :
			wr_data; // [RL3]
		st_next.resume_valid = 1'b0;
		st_next.rd_a_data = read_reg(st_reg, rd_a_idx, rd_a_narrow, rd_a_sp_form);
		st_next.rd_b_data = read_reg(st_reg, rd_b_idx, rd_b_narrow, rd_b_sp_form);
		// No index reaches the program counter; it lives outside this block
		if (wr_en) begin
			if (wr_idx != gpr_and_exception_state_regs_pkg::ZERO_IDX) begin
				st_next.wide_gprs[wr_idx] = wval; // [RL1] [RL13]
			end else if (wr_sp_form) begin
				st_next.stack_ptr[act_sp] = wval; // [RL5] [RL7] [RL12]
			end
		end
		if (flags_we) begin
			st_next.nzcv = flags_in;
		end
		if (ctrl_we) begin
			st_next.masks = masks_in;
			st_next.sp_sel = sp_sel_in;
			st_next.soft_step = soft_step_in;
			st_next.bad_state_flag = bad_state_in;
		end
		// Software access to a banked pair; level 0 has none and reads zero
		if (sr_rd_en) begin
			st_next.sr_rd_data = '0;
			if (sr_el != gpr_and_exception_state_regs_pkg::BASE_EL) begin
				st_next.sr_rd_data = (sr_sel == gpr_and_exception_state_regs_pkg::SR_SEL_STATE) ?
					{gpr_and_exception_state_regs_pkg::UPPER_ZERO, st_reg.saved_state_reg[sr_bank]} :
					st_reg.return_address_reg[sr_bank]; // [RL8]
			end
		end
		if (sr_wr_en && sr_el != gpr_and_exception_state_regs_pkg::BASE_EL) begin
			if (sr_sel == gpr_and_exception_state_regs_pkg::SR_SEL_STATE) begin
				st_next.saved_state_reg[sr_bank] = sr_wr_data[31:0];
			end else begin
				st_next.return_address_reg[sr_bank] = sr_wr_data;
			end
		end
		// Entry beats return and any write to the fields it sets in the same cycle
		if (exc_take && exc_target_el != gpr_and_exception_state_regs_pkg::BASE_EL) begin
			st_next.saved_state_reg[exc_bank] = pack_state(st_reg); // [RL15] [RL20] [RL23]
			st_next.return_address_reg[exc_bank] = exc_return_addr; // [RL14] [RL23]
			st_next.cur_el = exc_target_el;
			st_next.sp_sel = 1'b1; // [RL9] [RL23]
			st_next.exec_state = 1'b0;
		end else if (return_ok) begin
			st_next.nzcv = {restore[gpr_and_exception_state_regs_pkg::N_BIT],
				restore[gpr_and_exception_state_regs_pkg::Z_BIT],
				restore[gpr_and_exception_state_regs_pkg::C_BIT],
				restore[gpr_and_exception_state_regs_pkg::V_BIT]}; // [RL22]
			st_next.soft_step = restore[gpr_and_exception_state_regs_pkg::SS_BIT];
			st_next.bad_state_flag = restore[gpr_and_exception_state_regs_pkg::BAD_STATE_BIT];
			st_next.masks = {restore[gpr_and_exception_state_regs_pkg::D_BIT],
				restore[gpr_and_exception_state_regs_pkg::A_BIT],
				restore[gpr_and_exception_state_regs_pkg::I_BIT],
				restore[gpr_and_exception_state_regs_pkg::F_BIT]};
			st_next.exec_state = restore[gpr_and_exception_state_regs_pkg::M_STATE_BIT];
			st_next.cur_el = restore[gpr_and_exception_state_regs_pkg::M_EL_LO +: 2];
			st_next.sp_sel = restore[gpr_and_exception_state_regs_pkg::M_SPSEL_BIT];
			st_next.resume_pc = st_reg.return_address_reg[cur_bank]; // [RL22]
			st_next.resume_valid = 1'b1;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			st_reg <= '0;
			st_reg.cur_el <= gpr_and_exception_state_regs_pkg::RESET_EL;
			st_reg.sp_sel <= gpr_and_exception_state_regs_pkg::RESET_SPSEL;
			st_reg.masks <= gpr_and_exception_state_regs_pkg::RESET_MASKS;
		end else begin
			st_reg <= st_next;
		end
	end

	assign rd_a_data = st_reg.rd_a_data;
	assign rd_b_data = st_reg.rd_b_data;
	assign sr_rd_data = st_reg.sr_rd_data;
	assign resume_pc = st_reg.resume_pc;
	assign resume_valid = st_reg.resume_valid;
	assign cur_el = st_reg.cur_el;
	assign sp_sel = st_reg.sp_sel;
	assign nzcv = st_reg.nzcv;
	assign masks = st_reg.masks;
	assign soft_step = st_reg.soft_step;
	assign bad_state_flag = st_reg.bad_state_flag;
	assign exec_state = st_reg.exec_state;

	// Checks
	zero_read_a: assert property (@(posedge sys_clk) disable iff (rst) // [RL4] [RL6]
		(rd_a_idx == 5'h1F && !rd_a_sp_form) |=> rd_a_data == 64'h0)
		else $error("zero register read not zero");
	narrow_read_a: assert property (@(posedge sys_clk) disable iff (rst) // [RL2]
		rd_a_narrow |=> rd_a_data[63:32] == 32'h0)
		else $error("narrow read upper half not zero");
	narrow_write_a: assert property (@(posedge sys_clk) disable iff (rst) // [RL3]
		(wr_en && wr_narrow && wr_idx != 5'h1F && !exc_take) ##1
		(rd_a_idx == $past(wr_idx) && !rd_a_narrow && !(wr_en && wr_idx == rd_a_idx))
		|=> rd_a_data == {32'h0, $past(wr_data[31:0], 2)})
		else $error("narrow write did not clear upper half");
	base_sp_only_a: assert property (@(posedge sys_clk) disable iff (rst) // [RL11]
		(cur_el == 2'h0 && rd_a_idx == 5'h1F && rd_a_sp_form && !rd_a_narrow) |=>
		rd_a_data == $past(st_reg.stack_ptr[0]))
		else $error("level 0 used a non-base stack pointer");
	entry_select_a: assert property (@(posedge sys_clk) disable iff (rst) // [RL9]
		(exc_take && exc_target_el != 2'h0) |=> cur_el == $past(exc_target_el) && sp_sel)
		else $error("entry did not select target level pointer");
	entry_capture_a: assert property (@(posedge sys_clk) disable iff (rst) // [RL15] [RL20]
		(exc_take && exc_target_el != 2'h0) |=>
		st_reg.saved_state_reg[$past(exc_bank)] == $past(pack_state(st_reg)) &&
		st_reg.return_address_reg[$past(exc_bank)] == $past(exc_return_addr))
		else $error("entry did not capture state and return address");
	flag_layout_a: assert property (@(posedge sys_clk) disable iff (rst) // [RL16] [RL18]
		(exc_take && exc_target_el == 2'h3) |=>
		st_reg.saved_state_reg[2][31:28] == $past(nzcv) &&
		st_reg.saved_state_reg[2][9:6] == $past(masks) &&
		st_reg.saved_state_reg[2][3:2] == $past(cur_el))
		else $error("saved state field layout wrong");
	bank_hold_a: assert property (@(posedge sys_clk) disable iff (rst) // [RL21]
		(cur_el != 2'h3 && !(exc_take && exc_target_el == 2'h3) &&
		!(sr_wr_en && sr_el == 2'h3)) |=> $stable(st_reg.saved_state_reg[2]) &&
		$stable(st_reg.return_address_reg[2]))
		else $error("level 3 banked pair changed at lower level");
	return_resume_a: assert property (@(posedge sys_clk) disable iff (rst) // [RL22]
		(exception_return_op && !exc_take && cur_el != 2'h0) |=>
		resume_valid && resume_pc == $past(st_reg.return_address_reg[cur_bank]) &&
		cur_el == $past(restore[3:2]))
		else $error("return did not restore state and resume address");
	// Stack pointer writes, refusals and saved-state bit placement
	sp_write_a: assert property (@(posedge sys_clk) disable iff (rst) // [RL5] [RL12]
		(wr_en && wr_idx == 5'h1F && wr_sp_form && !wr_narrow &&
		cur_el != 2'h0 && sp_sel) |=>
		st_reg.stack_ptr[$past(cur_el)] == $past(wr_data))
		else $error("stack pointer write missed the level pointer");
	zero_write_a: assert property (@(posedge sys_clk) disable iff (rst) // [RL6]
		(wr_en && wr_idx == 5'h1F && !wr_sp_form) |=>
		$stable(st_reg.wide_gprs) &&
		$stable(st_reg.stack_ptr))
		else $error("zero register write changed state");
	return_refused_a: assert property (@(posedge sys_clk) disable iff (rst) // [RL8]
		(exception_return_op && !exc_take && cur_el == 2'h0) |=>
		!resume_valid && cur_el == 2'h0)
		else $error("return accepted at level 0");
	level_zero_read_a: assert property (@(posedge sys_clk) disable iff (rst) // [RL8]
		(sr_rd_en && sr_el == 2'h0) |=> sr_rd_data == 64'h0)
		else $error("level 0 banked read not zero");
	step_bits_a: assert property (@(posedge sys_clk) disable iff (rst) // [RL17] [RL19]
		(exc_take && exc_target_el != 2'h0) |=>
		st_reg.saved_state_reg[$past(exc_bank)][21] == $past(soft_step) &&
		st_reg.saved_state_reg[$past(exc_bank)][20] == $past(bad_state_flag) &&
		st_reg.saved_state_reg[$past(exc_bank)][4] == $past(exec_state))
		else $error("step, bad state or source state bit misplaced");
	entry_cov_c: cover property (@(posedge sys_clk) disable iff (rst)
		exc_take && exc_target_el == 2'h1 && cur_el == 2'h0);
	return_cov_c: cover property (@(posedge sys_clk) disable iff (rst)
		exception_return_op && cur_el == 2'h1 ##1 cur_el == 2'h0);
	sp_write_cov_c: cover property (@(posedge sys_clk) disable iff (rst)
		wr_en && wr_idx == 5'h1F && wr_sp_form && cur_el != 2'h0);
	narrow_cov_c: cover property (@(posedge sys_clk) disable iff (rst)
		wr_en && wr_narrow && wr_idx != 5'h1F);
	base_sp_cov_c: cover property (@(posedge sys_clk) disable iff (rst)
		cur_el != 2'h0 && !sp_sel && rd_a_idx == 5'h1F && rd_a_sp_form);
endmodule // gpr_and_exception_state_regs

// ### tb/exc_sequencer.sv
// Exception sequencer model that drives entry and return strobes into the register file
`timescale 1ns/1ps
module exc_sequencer (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// Requests from the bench, and the running level from the register file
	input wire logic req_take,
	input wire logic [1:0] req_target,
	input wire logic [63:0] req_addr,
	input wire logic req_ret,
	input wire logic [1:0] cur_el,
	// Strobes toward the register file
	output logic exc_take,
	output logic [1:0] exc_target_el,
	output logic [63:0] exc_return_addr,
	output logic exception_return_op
);
	logic [63:0] addr_reg;
	// Address is only meaningful with the entry strobe; otherwise it shows garbage
	assign exc_return_addr = exc_take ? addr_reg : ~addr_reg;
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			exc_take <= 1'b0;
			exc_target_el <= 2'h0;
			addr_reg <= 64'h0;
			exception_return_op <= 1'b0;
		end else begin
			// Entry below the running level is never offered
			exc_take <= req_take && (req_target >= cur_el);
			exc_target_el <= req_target;
			addr_reg <= req_addr;
			exception_return_op <= req_ret;
		end
	end
endmodule // exc_sequencer

// ### tb/gpr_and_exception_state_regs_tb.sv
// Self-checking bench for the register file and exception state
`timescale 1ns/1ps
`define CHK(n, e, g) begin \
	checked++; \
	if ((g) !== (e)) begin \
		num_errors++; \
		$display("BAD %s exp %h got %h", n, e, g); \
	end \
end
module gpr_and_exception_state_regs_tb;
	typedef struct packed {
		logic w_en;
		logic [4:0] w_idx;
		logic w_nar;
		logic w_sp;
		logic [63:0] w_data;
		logic [4:0] r_idx;
		logic r_nar;
		logic r_sp;
		logic [63:0] exp;
	} row_t;
	logic sys_clk = 1'b0, rst = 1'b1, wr_en = 1'b0, wr_narrow = 1'b0, wr_sp_form = 1'b0;
	logic rd_a_narrow = 1'b0, rd_a_sp_form = 1'b0, flags_we = 1'b0, ctrl_we = 1'b0;
	logic sp_sel_in = 1'b0, soft_step_in = 1'b0, bad_state_in = 1'b0, req_take = 1'b0;
	logic sr_rd_en = 1'b0, sr_wr_en = 1'b0, sr_sel = 1'b0, req_ret = 1'b0;
	logic [4:0] rd_a_idx = 5'h00, wr_idx = 5'h00;
	logic [3:0] flags_in = 4'h0, masks_in = 4'h0, nzcv, masks;
	logic [1:0] sr_el = 2'h0, req_target = 2'h0, cur_el, exc_target_el;
	logic [63:0] wr_data = 64'h0, sr_wr_data = 64'h0, req_addr = 64'h0;
	logic [63:0] rd_a_data, rd_b_data, resume_pc, sr_rd_data, exc_return_addr;
	logic sp_sel, soft_step, bad_state_flag, exec_state, resume_valid, exc_take;
	logic exception_return_op;
	wire logic [4:0] rd_b_idx = rd_a_idx;
	wire logic rd_b_narrow = rd_a_narrow;
	wire logic rd_b_sp_form = rd_a_sp_form;
	int checked = 0;
	int num_errors = 0;
	row_t rows [10] = '{
		'{1'b1, 5'h05, 1'b0, 1'b0, 64'h0123456789ABCDEF, 5'h05, 1'b0, 1'b0, 64'h0123456789ABCDEF},
		'{1'b1, 5'h03, 1'b1, 1'b0, 64'hFFFFFFFFFFFFFFFF, 5'h03, 1'b0, 1'b0, 64'h00000000FFFFFFFF},
		'{1'b1, 5'h07, 1'b0, 1'b0, 64'hFEDCBA9876543210, 5'h07, 1'b1, 1'b0, 64'h0000000076543210},
		'{1'b0, 5'h07, 1'b0, 1'b0, 64'h0, 5'h07, 1'b0, 1'b0, 64'hFEDCBA9876543210},
		'{1'b1, 5'h1F, 1'b0, 1'b0, 64'h1111111111111111, 5'h1F, 1'b0, 1'b0, 64'h0},
		'{1'b0, 5'h1F, 1'b0, 1'b0, 64'h0, 5'h1F, 1'b1, 1'b0, 64'h0},
		'{1'b1, 5'h1F, 1'b0, 1'b1, 64'hAAAABBBBCCCCDDDD, 5'h1F, 1'b0, 1'b1, 64'hAAAABBBBCCCCDDDD},
		'{1'b1, 5'h1F, 1'b1, 1'b1, 64'h9999888877776666, 5'h1F, 1'b0, 1'b1, 64'h0000000077776666},
		'{1'b1, 5'h1E, 1'b0, 1'b0, 64'h5555666677778888, 5'h1E, 1'b0, 1'b0, 64'h5555666677778888},
		'{1'b1, 5'h00, 1'b1, 1'b0, 64'h123456789ABCDEF0, 5'h00, 1'b0, 1'b0, 64'h000000009ABCDEF0}
	};

	gpr_and_exception_state_regs dut (
		.sys_clk, .rst, .rd_a_idx, .rd_a_narrow, .rd_a_sp_form, .rd_a_data, .rd_b_idx,
		.rd_b_narrow, .rd_b_sp_form, .rd_b_data, .wr_en, .wr_idx, .wr_narrow, .wr_sp_form,
		.wr_data, .flags_we, .flags_in, .ctrl_we, .masks_in, .sp_sel_in, .soft_step_in,
		.bad_state_in, .exc_take, .exc_target_el, .exc_return_addr, .exception_return_op,
		.resume_pc, .resume_valid, .sr_rd_en, .sr_wr_en, .sr_sel, .sr_el, .sr_wr_data,
		.sr_rd_data, .cur_el, .sp_sel, .nzcv, .masks, .soft_step, .bad_state_flag, .exec_state
	);
	exc_sequencer partner (
		.sys_clk, .rst, .req_take, .req_target, .req_addr, .req_ret, .cur_el, .exc_take,
		.exc_target_el, .exc_return_addr, .exception_return_op
	);

	initial begin
		forever #2.5 sys_clk = ~sys_clk;
	end
	task cyc;
		@(posedge sys_clk);
		#1;
	endtask
	task wr(input logic [4:0] i, input logic n, input logic s, input logic [63:0] d);
		{wr_en, wr_idx, wr_narrow, wr_sp_form, wr_data} = {1'b1, i, n, s, d};
		cyc;
		wr_en = 1'b0;
	endtask
	task rd(input logic [4:0] i, input logic n, input logic s);
		{rd_a_idx, rd_a_narrow, rd_a_sp_form} = {i, n, s};
		cyc;
	endtask
	task sr_rd(input logic sel, input logic [1:0] el);
		{sr_rd_en, sr_sel, sr_el} = {1'b1, sel, el};
		cyc;
	endtask
	task ctl(input logic [3:0] m, input logic s, input logic ss, input logic il);
		{ctrl_we, masks_in, sp_sel_in, soft_step_in, bad_state_in} = {1'b1, m, s, ss, il};
		cyc;
		{ctrl_we, flags_we} = 2'b00;
	endtask
	task ent(input logic [1:0] t, input logic [63:0] a);
		{req_take, req_target, req_addr} = {1'b1, t, a};
		cyc;
		req_take = 1'b0;
		cyc;
	endtask
	task ret;
		req_ret = 1'b1;
		cyc;
		req_ret = 1'b0;
		cyc;
	endtask
	task wrap_up;
		$display("checked %0d num_errors %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	initial begin
		repeat (5) @(posedge sys_clk);
		#1;
		rst = 1'b0;
		`CHK("reset", {2'h3, 1'b1, 4'hF, 4'h0, 1'b0}, {cur_el, sp_sel, masks, nzcv, resume_valid})
		cyc;
		foreach (rows[k]) begin
			if (rows[k].w_en)
				wr(rows[k].w_idx, rows[k].w_nar, rows[k].w_sp, rows[k].w_data);
			rd(rows[k].r_idx, rows[k].r_nar, rows[k].r_sp);
			`CHK("rd_a", rows[k].exp, rd_a_data)
			`CHK("rd_b", rows[k].exp, rd_b_data)
		end
		{flags_we, flags_in} = {1'b1, 4'hA};
		ctl(4'h5, 1'b0, 1'b1, 1'b1);
		`CHK("ctl", {4'hA, 4'h5, 1'b0, 1'b1, 1'b1}, {nzcv, masks, sp_sel, soft_step, bad_state_flag})
		rd(5'h1F, 1'b0, 1'b1);
		`CHK("base sp", 64'h0, rd_a_data)
		wr(5'h1F, 1'b0, 1'b1, 64'h00000000B0B0B0B0);
		ent(2'h3, 64'h00000000A3A3A3A0);
		`CHK("entry", {2'h3, 1'b1, 1'b0}, {cur_el, sp_sel, exec_state})
		rd(5'h1F, 1'b0, 1'b1);
		`CHK("level sp", 64'h0000000077776666, rd_a_data)
		sr_rd(1'b0, 2'h3);
		`CHK("saved 3", 64'h00000000A030014C, sr_rd_data)
		sr_rd(1'b1, 2'h3);
		`CHK("ret addr 3", 64'h00000000A3A3A3A0, sr_rd_data)
		sr_rd_en = 1'b0;
		{sr_wr_en, sr_sel, sr_el, sr_wr_data} = {1'b1, 1'b0, 2'h3, 64'h0000000060000010};
		cyc;
		sr_wr_en = 1'b0;
		`CHK("sr hold", 64'h00000000A3A3A3A0, sr_rd_data)
		ret;
		`CHK("return", {1'b1, 2'h0, 4'h6}, {resume_valid, cur_el, nzcv})
		`CHK("restored", 8'h01, {masks, sp_sel, soft_step, bad_state_flag, exec_state})
		`CHK("resume pc", 64'h00000000A3A3A3A0, resume_pc)
		cyc;
		`CHK("resume pulse", 1'b0, resume_valid)
		ctl(4'h0, 1'b1, 1'b0, 1'b0);
		rd(5'h1F, 1'b0, 1'b1);
		`CHK("level 0 sp", 64'h00000000B0B0B0B0, rd_a_data)
		ret;
		`CHK("level 0 return", {1'b0, 2'h0}, {resume_valid, cur_el})
		ent(2'h1, 64'h00000000A1A1A1A0);
		`CHK("entry 1", {2'h1, 1'b1, 1'b0}, {cur_el, sp_sel, exec_state})
		sr_rd(1'b0, 2'h1);
		`CHK("saved 1", 64'h0000000060000011, sr_rd_data)
		sr_rd(1'b1, 2'h1);
		`CHK("ret addr 1", 64'h00000000A1A1A1A0, sr_rd_data)
		sr_rd(1'b0, 2'h3);
		`CHK("saved 3 kept", 64'h0000000060000010, sr_rd_data)
		sr_rd(1'b1, 2'h3);
		`CHK("addr 3 kept", 64'h00000000A3A3A3A0, sr_rd_data)
		sr_rd(1'b0, 2'h0);
		`CHK("no bank 0", 64'h0, sr_rd_data)
		wrap_up;
	end
	initial begin
		#20000;
		num_errors++;
		wrap_up;
	end
endmodule // gpr_and_exception_state_regs_tb
